// ===== rtl/gpio_pkg.sv
// package: register map, reset values and field positions of the gpio port block
package gpio_pkg;
  localparam int unsigned NUM_PORTS  = 4;
  localparam int unsigned PORT_WIDTH = 8;

  // register byte offsets on the ahb-lite bus
  localparam logic [7:0] ADDR_DATA0      = 8'h00;
  localparam logic [7:0] ADDR_DIR0       = 8'h10;
  localparam logic [7:0] ADDR_BITOP      = 8'h20;
  localparam logic [7:0] ADDR_PULLUP_EN  = 8'h24;
  localparam logic [7:0] ADDR_WAKE_SEL   = 8'h28;
  localparam logic [7:0] ADDR_SHARE_C    = 8'h2c;
  localparam logic [7:0] ADDR_SHARE_D    = 8'h30;
  localparam logic [7:0] ADDR_SHARE_INT  = 8'h34;
  localparam logic [7:0] ADDR_CONV_CTRL  = 8'h38;
  localparam logic [7:0] ADDR_CONV_SEL   = 8'h3c;
  localparam logic [7:0] ADDR_POWER_DOWN = 8'h40;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h44;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h48;

  // reset values
  localparam logic [7:0] RST_DATA      = 8'hff;
  localparam logic [7:0] RST_DIR       = 8'hff;
  localparam logic [7:0] RST_ZERO      = 8'h00;

  // bit-operation register fields: [2:0] bit, [5:4] port, [8] set/clear value
  localparam int unsigned BITOP_BIT_LSB  = 0;
  localparam int unsigned BITOP_PORT_LSB = 4;
  localparam int unsigned BITOP_VAL_POS  = 8;

  // converter control field positions
  localparam int unsigned CONV_CH_LSB    = 3;
  localparam int unsigned CONV_EN_POS    = 4;

  // interrupt status bits
  localparam int unsigned IRQ_WAKE_POS   = 0;
  localparam int unsigned IRQ_EXT_POS    = 1;
  localparam int unsigned IRQ_WIDTH      = 2;

  // external interrupt and oscillator sharing
  localparam int unsigned EXT_INT_PIN    = 5;
  localparam int unsigned OSC_LINES      = 4;
endpackage : gpio_pkg

// ===== rtl/gpio_sync_if.sv
// interface: synchronised pin levels between the sync stage and the port logic
interface gpio_sync_if;
  logic [31:0] raw;
  logic [31:0] level;
  modport sync (input raw, output level);
  modport user (output raw, input level);
endinterface : gpio_sync_if

// ===== rtl/gpio_pin_sync.sv
// module: two-flop synchroniser for all port pin inputs
module gpio_pin_sync (
  // clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_rst,
  // pins
  gpio_sync_if.sync   sif
);
  typedef struct packed {
    logic [31:0] meta;
    logic [31:0] level;
  } gpio_sync_s;

  gpio_sync_s st;
  gpio_sync_s next_st;

  always_comb begin
    next_st       = st;
    next_st.meta  = sif.raw;
    next_st.level = st.meta;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sif.level = st.level;
endmodule // gpio_pin_sync

// ===== rtl/gpio_ports.sv
// module: four bidirectional 8-bit ports with ahb-lite registers, wake-up and interrupts
module gpio_ports (
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  // ahb-lite slave
  input  wire logic        I_HSEL,
  input  wire logic [7:0]  I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic      [31:0] O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  // port pins, index 8*port+bit
  input  wire logic [31:0] I_PIN,
  output logic      [31:0] O_PIN,
  output logic      [31:0] O_PIN_OE_N,
  output logic      [31:0] O_PULLUP,
  // shared functions
  output logic      [7:0]  O_ANALOG_SEL,
  output logic      [7:0]  O_SWITCH_SEL,
  output logic      [3:0]  O_OSC_SEL,
  output logic             O_EXT_INT,
  // power and interrupt
  output logic             O_POWER_DOWN,
  output logic             O_IRQ
);
  localparam int unsigned W = gpio_pkg::PORT_WIDTH;

  typedef struct packed {
    logic [31:0] data;
    logic [31:0] dir;
    logic [3:0]  pullup_en;
    logic [7:0]  wake_sel;
    logic [7:0]  share_c;
    logic [3:0]  share_d;
    logic        share_int;
    logic [7:0]  conv_ctrl;
    logic [7:0]  conv_sel;
    logic        power_down;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic [7:0]  pa_prev;
    logic        ext_prev;
    logic        dp_write;
    logic [7:0]  dp_addr;
    logic [31:0] rdata;
  } gpio_ports_s;

  gpio_ports_s st;
  gpio_ports_s next_st;

  gpio_sync_if sif ();
  assign sif.raw = I_PIN;

  gpio_pin_sync u_sync (
    .i_clk (I_CLK),
    .i_rst (I_RST),
    .sif   (sif)
  );

  logic [31:0] pin_level;
  logic [31:0] shared;
  logic [31:0] port_view;
  logic [7:0]  analog;
  logic        addr_phase;
  logic [7:0]  fall;
  logic [2:0]  bit_idx;
  logic [1:0]  port_idx;
  logic [7:0]  rmw;
  logic [31:0] wd;

  assign pin_level = sif.level;

  // analog select: when the converter is enabled, the conv_sel mask picks the analog pins
  always_comb begin
    analog = '0;
    if (st.conv_ctrl[gpio_pkg::CONV_EN_POS]) begin
      analog = st.conv_sel;
    end
  end

  // pins owned by shared functions
  always_comb begin
    shared = '0;
    shared[2*W +: W] = st.share_c;
    shared[3*W +: gpio_pkg::OSC_LINES] = st.share_d;
    shared[W +: W] = analog;
  end

  // readable port view: input pins live, output pins from the latch
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_pin
      assign port_view[g] = st.dir[g] ? pin_level[g] : st.data[g];
      assign O_PIN[g]      = st.data[g];
      assign O_PIN_OE_N[g] = st.dir[g] | shared[g];
      assign O_PULLUP[g]   = st.pullup_en[g / W] & st.dir[g] & ~shared[g];
    end
  endgenerate

  assign O_ANALOG_SEL = analog;
  assign O_SWITCH_SEL = st.share_c;
  assign O_OSC_SEL    = st.share_d;
  // external interrupt only when selected and the pin is an input
  assign O_EXT_INT    = st.share_int & st.dir[gpio_pkg::EXT_INT_PIN] &
                        pin_level[gpio_pkg::EXT_INT_PIN];

  assign addr_phase = I_HSEL & I_HREADY & I_HTRANS[1];
  assign fall       = st.pa_prev & ~pin_level[W-1:0] & st.wake_sel;
  assign wd         = I_HWDATA;
  assign bit_idx    = wd[gpio_pkg::BITOP_BIT_LSB +: 3];
  assign port_idx   = wd[gpio_pkg::BITOP_PORT_LSB +: 2];

  // read-modify-write source byte for single bit operations
  always_comb begin
    rmw = port_view[port_idx*W +: W];
    rmw[bit_idx] = wd[gpio_pkg::BITOP_VAL_POS];
  end

  always_comb begin
    next_st          = st;
    next_st.pa_prev  = pin_level[W-1:0];
    next_st.ext_prev = O_EXT_INT;
    next_st.dp_write = 1'b0;
    if (addr_phase) begin
      next_st.dp_write = I_HWRITE;
      next_st.dp_addr  = I_HADDR;
      next_st.rdata    = '0;
      case (I_HADDR)
        gpio_pkg::ADDR_DATA0,
        gpio_pkg::ADDR_DATA0 + 8'h04,
        gpio_pkg::ADDR_DATA0 + 8'h08,
        gpio_pkg::ADDR_DATA0 + 8'h0c: begin
          next_st.rdata[W-1:0] = port_view[I_HADDR[3:2]*W +: W];
        end
        gpio_pkg::ADDR_DIR0,
        gpio_pkg::ADDR_DIR0 + 8'h04,
        gpio_pkg::ADDR_DIR0 + 8'h08,
        gpio_pkg::ADDR_DIR0 + 8'h0c: begin
          next_st.rdata[W-1:0] = st.dir[I_HADDR[3:2]*W +: W];
        end
        gpio_pkg::ADDR_PULLUP_EN:  next_st.rdata[3:0] = st.pullup_en;
        gpio_pkg::ADDR_WAKE_SEL:   next_st.rdata[7:0] = st.wake_sel;
        gpio_pkg::ADDR_SHARE_C:    next_st.rdata[7:0] = st.share_c;
        gpio_pkg::ADDR_SHARE_D:    next_st.rdata[3:0] = st.share_d;
        gpio_pkg::ADDR_SHARE_INT:  next_st.rdata[0]   = st.share_int;
        gpio_pkg::ADDR_CONV_CTRL:  next_st.rdata[7:0] = st.conv_ctrl;
        gpio_pkg::ADDR_CONV_SEL:   next_st.rdata[7:0] = st.conv_sel;
        gpio_pkg::ADDR_POWER_DOWN: next_st.rdata[0]   = st.power_down;
        gpio_pkg::ADDR_IRQ_STATUS: next_st.rdata[1:0] = st.irq_status;
        gpio_pkg::ADDR_IRQ_MASK:   next_st.rdata[1:0] = st.irq_mask;
        default:                   next_st.rdata      = '0;
      endcase
    end
    // data phase writes
    if (st.dp_write) begin
      case (st.dp_addr)
        gpio_pkg::ADDR_DATA0,
        gpio_pkg::ADDR_DATA0 + 8'h04,
        gpio_pkg::ADDR_DATA0 + 8'h08,
        gpio_pkg::ADDR_DATA0 + 8'h0c: begin
          next_st.data[st.dp_addr[3:2]*W +: W] = wd[W-1:0];
        end
        gpio_pkg::ADDR_DIR0,
        gpio_pkg::ADDR_DIR0 + 8'h04,
        gpio_pkg::ADDR_DIR0 + 8'h08,
        gpio_pkg::ADDR_DIR0 + 8'h0c: begin
          next_st.dir[st.dp_addr[3:2]*W +: W] = wd[W-1:0];
        end
        gpio_pkg::ADDR_BITOP:      next_st.data[port_idx*W +: W] = rmw;
        gpio_pkg::ADDR_PULLUP_EN:  next_st.pullup_en  = wd[3:0];
        gpio_pkg::ADDR_WAKE_SEL:   next_st.wake_sel   = wd[7:0];
        gpio_pkg::ADDR_SHARE_C:    next_st.share_c    = wd[7:0];
        gpio_pkg::ADDR_SHARE_D:    next_st.share_d    = wd[3:0];
        gpio_pkg::ADDR_SHARE_INT:  next_st.share_int  = wd[0];
        gpio_pkg::ADDR_CONV_CTRL:  next_st.conv_ctrl  = wd[7:0];
        gpio_pkg::ADDR_CONV_SEL:   next_st.conv_sel   = wd[7:0];
        gpio_pkg::ADDR_POWER_DOWN: next_st.power_down = wd[0];
        gpio_pkg::ADDR_IRQ_STATUS: next_st.irq_status = st.irq_status & ~wd[1:0];
        gpio_pkg::ADDR_IRQ_MASK:   next_st.irq_mask   = wd[1:0];
        default: ;
      endcase
    end
    // wake on a selected falling port a pin; set wins over clear
    if (st.power_down && (|fall)) begin
      next_st.power_down = 1'b0;
      next_st.irq_status[gpio_pkg::IRQ_WAKE_POS] = 1'b1;
    end
    // external interrupt on falling edge of the shared line
    if (st.ext_prev && !O_EXT_INT && st.share_int) begin
      next_st.irq_status[gpio_pkg::IRQ_EXT_POS] = 1'b1;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      st            <= '0;
      st.data       <= {4{gpio_pkg::RST_DATA}};
      st.dir        <= {4{gpio_pkg::RST_DIR}};
      st.pa_prev    <= gpio_pkg::RST_ZERO;
    end else begin
      st <= next_st;
    end
  end

  assign O_HRDATA     = st.rdata;
  assign O_HREADYOUT  = 1'b1;
  assign O_HRESP      = 1'b0;
  assign O_POWER_DOWN = st.power_down;
  assign O_IRQ        = |(st.irq_status & st.irq_mask);
endmodule // gpio_ports

// ===== testbench/gpio_pins_model.sv
// board model: resolves each pad level from device drive, board drive and pull-up
module gpio_pins_model (
  // clock
  input  wire logic        i_clk,
  // device side
  input  wire logic [31:0] i_pin,
  input  wire logic [31:0] i_oe_n,
  input  wire logic [31:0] i_pullup,
  // board side
  input  wire logic [31:0] i_drv,
  input  wire logic [31:0] i_drv_en,
  output logic      [31:0] o_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] wander = 32'h0;
  // an undriven pad without pull-up never keeps a stale level
  always @(posedge i_clk) wander <= ~wander;
  // board holds its drive between edges; device push-pull wins
  assign o_level = (~i_oe_n & i_pin) | (i_oe_n & i_drv_en & i_drv)
                 | (i_oe_n & ~i_drv_en & (i_pullup | wander));
endmodule // gpio_pins_model

// ===== testbench/gpio_ports_sva.sv
// checker: port-level assertions for the gpio port block
module gpio_ports_sva (
  // clock and reset
  input wire logic        I_CLK,
  input wire logic        I_RST,
  // bus
  input wire logic        I_HSEL,
  input wire logic [1:0]  I_HTRANS,
  input wire logic        I_HWRITE,
  input wire logic        I_HREADY,
  // pins and shared functions
  input wire logic [31:0] I_PIN,
  input wire logic [31:0] O_PIN,
  input wire logic [31:0] O_PIN_OE_N,
  input wire logic [31:0] O_PULLUP,
  input wire logic [7:0]  O_ANALOG_SEL,
  input wire logic [7:0]  O_SWITCH_SEL,
  input wire logic [3:0]  O_OSC_SEL,
  input wire logic        O_EXT_INT
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  logic wr_take;
  assign wr_take = I_HSEL & I_HREADY & I_HTRANS[1] & I_HWRITE;
  sequence s_release; $fell(I_RST); endsequence
  sequence s_all_input; O_PIN_OE_N == 32'hffffffff && O_PIN == 32'hffffffff; endsequence
  property p_reset; s_release |-> s_all_input; endproperty
  a_reset: assert property (p_reset) else $error("pins not input after reset");
  property p_latch; $changed(O_PIN) |-> $past(wr_take, 2); endproperty
  a_latch: assert property (p_latch) else $error("latch moved without write");
  property p_pull; (O_PULLUP & ~O_PIN_OE_N) == 32'h0; endproperty
  a_pull: assert property (p_pull) else $error("pull-up on driven pin");
  property p_ana; (O_PULLUP[15:8] & O_ANALOG_SEL) == 8'h00; endproperty
  a_ana: assert property (p_ana) else $error("pull-up on analog pin");
  property p_sw; (O_PIN_OE_N[23:16] & O_SWITCH_SEL) == O_SWITCH_SEL; endproperty
  a_sw: assert property (p_sw) else $error("switch pin driven");
  property p_osc; (O_PIN_OE_N[27:24] & O_OSC_SEL) == O_OSC_SEL; endproperty
  a_osc: assert property (p_osc) else $error("oscillator pin driven");
  property p_shpu;
    (O_PULLUP[23:16] & O_SWITCH_SEL) == 8'h00 && (O_PULLUP[27:24] & O_OSC_SEL) == 4'h0;
  endproperty
  a_shpu: assert property (p_shpu) else $error("pull-up on shared pin");
  property p_ext; O_EXT_INT |-> O_PIN_OE_N[5] && $past(I_PIN[5], 2); endproperty
  a_ext: assert property (p_ext) else $error("interrupt line not from input pin");
endmodule // gpio_ports_sva
bind gpio_ports gpio_ports_sva i_sva (.I_CLK(I_CLK), .I_RST(I_RST), .I_HSEL(I_HSEL),
  .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY), .I_PIN(I_PIN), .O_PIN(O_PIN),
  .O_PIN_OE_N(O_PIN_OE_N), .O_PULLUP(O_PULLUP), .O_ANALOG_SEL(O_ANALOG_SEL),
  .O_SWITCH_SEL(O_SWITCH_SEL), .O_OSC_SEL(O_OSC_SEL), .O_EXT_INT(O_EXT_INT));

// ===== testbench/tb.sv
// testbench: bus-driven scenarios for the gpio port block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} gpio_row_s;
  logic        I_CLK = 1'b0, I_RST = 1'b1, I_HSEL = 1'b1, I_HWRITE = 1'b0;
  logic [7:0]  I_HADDR = 8'h00;
  logic [1:0]  I_HTRANS = 2'h0;
  logic [31:0] I_HWDATA = 32'h0, drv = 32'h000000ff, O_HRDATA, O_PIN, O_PIN_OE_N, O_PULLUP;
  logic [31:0] pad, rd;
  logic        O_HREADYOUT, O_HRESP, O_EXT_INT, O_POWER_DOWN, O_IRQ;
  logic [7:0]  O_ANALOG_SEL, O_SWITCH_SEL;
  logic [3:0]  O_OSC_SEL;
  int          errors = 0, checks = 0, n;
  gpio_row_s   rows [13] = '{'{8'h10, 32'h0f, 32'h0f}, '{8'h00, 32'ha5, 32'haf},
    '{8'h14, 32'hff, 32'hff}, '{8'h18, 32'h00, 32'h00}, '{8'h1c, 32'h00, 32'h00},
    '{8'h24, 32'h0f, 32'h0f}, '{8'h28, 32'h01, 32'h01}, '{8'h2c, 32'h5a, 32'h5a},
    '{8'h30, 32'h1f, 32'h0f}, '{8'h38, 32'h10, 32'h10}, '{8'h3c, 32'h0f, 32'h0f},
    '{8'h48, 32'h01, 32'h01}, '{8'h4c, 32'hff, 32'h00}};
  gpio_ports i_dut (.I_CLK(I_CLK), .I_RST(I_RST), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR),
    .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HSIZE(3'h2), .I_HWDATA(I_HWDATA),
    .I_HREADY(O_HREADYOUT), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
    .I_PIN(pad), .O_PIN(O_PIN), .O_PIN_OE_N(O_PIN_OE_N), .O_PULLUP(O_PULLUP),
    .O_ANALOG_SEL(O_ANALOG_SEL), .O_SWITCH_SEL(O_SWITCH_SEL), .O_OSC_SEL(O_OSC_SEL),
    .O_EXT_INT(O_EXT_INT), .O_POWER_DOWN(O_POWER_DOWN), .O_IRQ(O_IRQ));
  gpio_pins_model i_pins (.i_clk(I_CLK), .i_pin(O_PIN), .i_oe_n(O_PIN_OE_N),
    .i_pullup(O_PULLUP), .i_drv(drv), .i_drv_en(32'hffff00ff), .o_level(pad));
  task automatic results();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    checks++;
    if (act !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, act, exp);
    end
  endtask
  task automatic hwait();
    int k;
    k = 0;
    @(posedge I_CLK);
    while (O_HREADYOUT !== 1'b1) begin
      k++;
      if (k > 20) begin
        errors++;
        results();
      end
      @(posedge I_CLK);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    I_HTRANS <= 2'h2;
    I_HADDR <= a;
    I_HWRITE <= w;
    hwait();
    I_HTRANS <= 2'h0;
    I_HWDATA <= d;
    hwait();
    rd = O_HRDATA;
  endtask
  initial forever #12.5 I_CLK = ~I_CLK;
  initial begin
    repeat (4) @(posedge I_CLK);
    I_RST <= 1'b0;
    @(negedge I_CLK);
    chk(O_PIN_OE_N, 32'hffffffff);
    chk(O_PIN, 32'hffffffff);
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].a, rows[i].d);
      xfer(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].e);
    end
    @(negedge I_CLK);
    chk(O_PIN_OE_N, 32'h0f5aff0f);
    chk(O_PULLUP, 32'h0000f00f);
    chk({16'h0, O_ANALOG_SEL, O_SWITCH_SEL}, 32'h0f5a);
    chk(32'(O_OSC_SEL), 32'hf);
    chk(O_PIN, 32'hffffffa5);
    $display("test table done");
    xfer(1'b1, 8'h20, 32'h007);
    xfer(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h2f);
    xfer(1'b1, 8'h20, 32'h033);
    @(posedge I_CLK);
    drv <= 32'h000000ff;
    xfer(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'hf7);
    chk(O_PIN[7:0], 32'h2f);
    $display("test bit ops done");
    xfer(1'b1, 8'h40, 32'h1);
    @(posedge I_CLK);
    drv <= 32'h000000fd;
    repeat (6) @(negedge I_CLK);
    chk(32'(O_POWER_DOWN), 32'h1);
    @(posedge I_CLK);
    drv <= 32'h000000fc;
    for (n = 0; n < 10 && O_POWER_DOWN !== 1'b0; n++) @(negedge I_CLK);
    if (n == 10) begin
      errors++;
      results();
    end
    chk(32'(O_IRQ), 32'h1);
    xfer(1'b1, 8'h48, 32'h0);
    @(negedge I_CLK);
    chk(32'(O_IRQ), 32'h0);
    xfer(1'b1, 8'h44, 32'h1);
    xfer(1'b1, 8'h48, 32'h1);
    @(negedge I_CLK);
    chk(32'(O_IRQ), 32'h0);
    $display("test wake done");
    xfer(1'b1, 8'h34, 32'h1);
    xfer(1'b1, 8'h10, 32'h2f);
    repeat (4) @(negedge I_CLK);
    chk(32'(O_EXT_INT), 32'h1);
    @(posedge I_CLK);
    drv <= 32'h000000dc;
    repeat (4) @(negedge I_CLK);
    chk(32'(O_EXT_INT), 32'h0);
    xfer(1'b0, 8'h44, 32'h0);
    chk(rd, 32'h2);
    chk(32'(O_HRESP), 32'h0);
    $display("test shared interrupt done");
    @(posedge I_CLK);
    I_RST <= 1'b1;
    repeat (4) @(posedge I_CLK);
    I_RST <= 1'b0;
    @(negedge I_CLK);
    chk(O_PIN_OE_N, 32'hffffffff);
    chk(O_PIN, 32'hffffffff);
    chk({30'h0, O_POWER_DOWN, O_IRQ}, 32'h0);
    xfer(1'b0, 8'h10, 32'h0);
    chk(rd, 32'hff);
    xfer(1'b0, 8'h44, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    results();
  end
endmodule // tb
